// ### src/mlt_table.sv
`timescale 1ns/100ps
`default_nettype none
`include "mlt_consts.svh"
module mlt_table #(
    parameter int PORTS  = `MLT_PORTS_DEF,
    parameter int DEPTH  = `MLT_DEPTH_DEF,
    parameter int CLK_HZ = `MLT_CLK_HZ
) (
    input  wire logic                clock,
    input  wire logic                rst,
    input  wire logic [5:0]          avs_address,
    input  wire logic                avs_read,
    input  wire logic                avs_write,
    input  wire logic [31:0]         avs_writedata,
    input  wire logic [3:0]          avs_byteenable,
    output logic [31:0]              avs_readdata,
    output logic                     avs_waitrequest,
    input  wire logic [PORTS-1:0]    mode_lock,
    input  wire logic                in_valid,
    output logic                     in_ready,
    input  wire mlt_pkg::mlt_pidx_t  in_port,
    input  wire mlt_pkg::mlt_vlan_t  in_vlan,
    input  wire mlt_pkg::mlt_hwaddr_t in_dest,
    input  wire mlt_pkg::mlt_hwaddr_t in_src,
    output logic                     out_valid,
    output logic [PORTS-1:0]         out_ports,
    output logic                     out_drop
);
    import mlt_pkg::*;
    localparam int AW = $clog2(DEPTH);
    localparam int EW = $bits(mlt_entry_t);
    localparam mlt_pmask_t PMASK = mlt_pmask_t'((64'h1 << PORTS) - 64'h1);
    localparam logic [AW:0] SMAX = (AW+1)'(`MLT_STATIC_MAX);
    typedef logic [AW-1:0] mlt_idx_t;
    typedef struct packed {
        mlt_state_t        state;
        mlt_op_t           op;
        mlt_idx_t          idx;
        mlt_idx_t          pidx;
        logic              pv;
        logic              last;
        mlt_key_t          key_a;
        mlt_key_t          key_b;
        logic              fa;
        logic              fb;
        logic              ffree;
        logic              fbest;
        mlt_idx_t          ia;
        mlt_idx_t          ib;
        mlt_idx_t          ifree;
        mlt_entry_t        ea;
        mlt_entry_t        eb;
        mlt_entry_t        best;
        logic [AW:0]       nstat;
        mlt_pidx_t         fport;
        logic              aging_off;
        mlt_sec_t          age_time;
        mlt_learn_t [31:0] mode;
        mlt_pidx_t         msel;
        mlt_vlan_t         kvlan;
        mlt_hwaddr_t       kaddr;
        mlt_pmask_t        kports;
        logic              cmd_pend;
        mlt_op_t           cmd_op;
        mlt_pidx_t         cmd_bit;
        logic              busy;
        logic              found;
        logic              err;
        mlt_entry_t        res;
        logic              age_pend;
        logic              waitreq;
        logic [31:0]       rdata;
        logic              in_ready;
        logic              out_valid;
        logic              out_drop;
        mlt_pmask_t        out_ports;
    } mlt_top_state_t;

    mlt_top_state_t st;
    mlt_top_state_t next_st;
    mlt_entry_t     e;
    mlt_entry_t     nent;
    mlt_key_t       ek;
    mlt_key_t       bk;
    mlt_pmask_t     lock32;
    mlt_pmask_t     onehot;
    mlt_learn_t     lm;
    logic [31:0]    bem;
    logic [31:0]    rd;
    logic [31:0]    wm;
    logic [31:0]    wv;
    logic           sec;
    logic           go;
    logic           tick;
    mlt_sec_t       now;

    if (PORTS < 1 || PORTS > 32 || DEPTH < `MLT_STATIC_MAX ||
        (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
        $error("Unsupported PORTS or DEPTH");
    end

    mlt_mem_if #(.AW(AW), .W(EW)) m ();

    mlt_mem #(.DEPTH(DEPTH), .AW(AW), .W(EW)) u_mem (
        .clock (clock),
        .m     (m)
    );

    mlt_sec_timer #(.CLK_HZ(CLK_HZ)) u_tmr (
        .clock (clock),
        .rst   (rst),
        .tick  (tick),
        .now   (now)
    );

    always_comb begin
        next_st = st;
        e = mlt_entry_t'(m.rdata);
        ek = {e.vlan, e.addr};
        bk = {st.best.vlan, st.best.addr};
        nent = '0;
        go = 1'b0;
        lock32 = mlt_pmask_t'(mode_lock);
        onehot = mlt_pmask_t'(32'h1) << st.fport;
        lm = st.mode[st.fport];
        sec = st.fb && st.eb.stat;
        bem = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
               {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
        wv = avs_writedata & bem;
        m.raddr = st.idx;
        m.we = 1'b0;
        m.waddr = st.pidx;
        m.wdata = '0;
        next_st.out_valid = 1'b0;
        next_st.waitreq = 1'b1;
        case (st.state)
            S_INIT: begin
                // Invalidate every slot before serving traffic
                m.we = 1'b1;
                m.waddr = st.idx;
                if (st.idx == AW'(DEPTH - 1)) begin
                    next_st.state = S_IDLE;
                    next_st.idx = '0;
                end else begin
                    next_st.idx = st.idx + 1'b1;
                end
            end
            S_IDLE: begin
                if (in_valid && st.in_ready) begin
                    next_st.op = OP_FRAME;
                    next_st.key_a = {in_vlan, in_dest};
                    next_st.key_b = {in_vlan, in_src};
                    next_st.fport = in_port;
                    go = 1'b1;
                end else if (st.age_pend) begin
                    next_st.age_pend = 1'b0;
                    next_st.op = OP_AGE;
                    go = !st.aging_off;
                end else if (st.cmd_pend) begin
                    next_st.cmd_pend = 1'b0;
                    next_st.op = st.cmd_op;
                    next_st.key_a = {st.kvlan, st.kaddr};
                    next_st.key_b = {st.kvlan, st.kaddr};
                    go = 1'b1;
                end
            end
            S_SCAN: begin
                if (st.pv) begin
                    if (e.valid && e.stat) begin
                        next_st.nstat = st.nstat + 1'b1;
                    end
                    if (!e.valid && !st.ffree) begin
                        next_st.ffree = 1'b1;
                        next_st.ifree = st.pidx;
                    end
                    if (e.valid && ek == st.key_a) begin
                        next_st.fa = 1'b1;
                        next_st.ia = st.pidx;
                        next_st.ea = e;
                    end
                    if (e.valid && ek == st.key_b) begin
                        next_st.fb = 1'b1;
                        next_st.ib = st.pidx;
                        next_st.eb = e;
                    end
                    // Smallest key not below the search key
                    if (e.valid && ek >= st.key_a &&
                        (!st.fbest || ek < bk)) begin
                        next_st.fbest = 1'b1;
                        next_st.best = e;
                    end
                    if (st.op == OP_AGE && e.valid && !e.stat &&
                        mlt_sec_t'(now - e.stamp) > st.age_time) begin
                        m.we = 1'b1;
                    end
                end
                if (!st.last) begin
                    next_st.pv = 1'b1;
                    next_st.pidx = st.idx;
                    if (st.idx == AW'(DEPTH - 1)) begin
                        next_st.last = 1'b1;
                    end else begin
                        next_st.idx = st.idx + 1'b1;
                    end
                end else begin
                    next_st.pv = 1'b0;
                    next_st.state = S_DONE;
                end
            end
            S_DONE: begin
                next_st.state = S_IDLE;
                next_st.busy = 1'b0;
                case (st.op)
                    OP_FRAME: begin
                        next_st.busy = st.busy;
                        next_st.out_valid = 1'b1;
                        next_st.out_drop = (lm == MLT_SECURE) && !sec;
                        if (next_st.out_drop) begin
                            next_st.out_ports = '0;
                        end else if (st.fa) begin
                            next_st.out_ports = st.ea.ports & PMASK;
                        end else begin
                            next_st.out_ports = PMASK & ~onehot;
                        end
                        nent = {1'b1, 1'b0, st.key_b, onehot & PMASK, now};
                        if (lm == MLT_AUTO && !sec) begin
                            if (st.fb) begin
                                m.we = 1'b1;
                                m.waddr = st.ib;
                            end else if (st.ffree) begin
                                m.we = 1'b1;
                                m.waddr = st.ifree;
                            end
                        end
                    end
                    OP_NEXT: begin
                        next_st.found = st.fbest;
                        next_st.res = st.best;
                    end
                    OP_ADD: begin
                        nent = {1'b1, 1'b1, st.key_a, st.kports & PMASK,
                                mlt_sec_t'(0)};
                        if (st.fa && (st.ea.stat || st.nstat < SMAX)) begin
                            m.we = 1'b1;
                            m.waddr = st.ia;
                        end else if (!st.fa && st.ffree && st.nstat < SMAX) begin
                            m.we = 1'b1;
                            m.waddr = st.ifree;
                        end else begin
                            next_st.err = 1'b1;
                        end
                    end
                    OP_DEL: begin
                        m.we = st.fa && st.ea.stat;
                        m.waddr = st.ia;
                        next_st.err = !(st.fa && st.ea.stat);
                    end
                    OP_SETB, OP_CLRB: begin
                        nent = st.ea;
                        nent.ports[st.cmd_bit] = (st.op == OP_SETB);
                        m.we = st.fa && st.ea.stat && 32'(st.cmd_bit) < PORTS;
                        m.waddr = st.ia;
                        next_st.err = !m.we;
                    end
                    default: begin
                        next_st.busy = st.busy;
                    end
                endcase
                m.wdata = nent;
            end
            default: begin
                next_st.state = S_IDLE;
            end
        endcase
        if (go) begin
            next_st.state = S_SCAN;
            next_st.idx = '0;
            next_st.pv = 1'b0;
            next_st.last = 1'b0;
            next_st.fa = 1'b0;
            next_st.fb = 1'b0;
            next_st.ffree = 1'b0;
            next_st.fbest = 1'b0;
            next_st.nstat = '0;
        end

        case ({avs_address[5:2], 2'b00})
            `MLT_REG_CTRL:   rd = {31'h0, st.aging_off};
            `MLT_REG_AGE:    rd = {8'h0, st.age_time};
            `MLT_REG_MODE: begin
                rd = {27'h0, st.msel};
                rd[`MLT_MODE_FLD +: 2] = st.mode[st.msel];
                rd[`MLT_MODE_LOCK] = lock32[st.msel];
            end
            `MLT_REG_KVLAN:  rd = {20'h0, st.kvlan};
            `MLT_REG_KADDRL: rd = st.kaddr[31:0];
            `MLT_REG_KADDRH: rd = {16'h0, st.kaddr[47:32]};
            `MLT_REG_KPORTS: rd = st.kports;
            `MLT_REG_CMD:    rd = {28'h0, st.err, st.res.stat, st.found,
                                   st.busy};
            `MLT_REG_RVLAN:  rd = {20'h0, st.res.vlan};
            `MLT_REG_RADDRL: rd = st.res.addr[31:0];
            `MLT_REG_RADDRH: rd = {16'h0, st.res.addr[47:32]};
            `MLT_REG_RPORTS: rd = st.res.ports;
            default:         rd = 32'h0;
        endcase
        wm = (rd & ~bem) | wv;
        // Write lands at the edge where the master sees waitrequest low
        if (avs_read || avs_write) begin
            next_st.waitreq = !st.waitreq;
            if (avs_read && st.waitreq) begin
                next_st.rdata = rd;
            end
            if (avs_write && !st.waitreq) begin
                case ({avs_address[5:2], 2'b00})
                    `MLT_REG_CTRL:   next_st.aging_off = wm[0];
                    `MLT_REG_AGE: begin
                        if (wm >= `MLT_AGE_MIN && wm <= `MLT_AGE_MAX) begin
                            next_st.age_time = wm[23:0];
                        end
                    end
                    `MLT_REG_MODE: begin
                        next_st.msel = wm[4:0];
                        if (wv[`MLT_MODE_APPLY] && !lock32[wm[4:0]] &&
                            32'(wm[4:0]) < PORTS &&
                            wm[`MLT_MODE_FLD +: 2] != 2'b11) begin
                            next_st.mode[wm[4:0]] =
                                mlt_learn_t'(wm[`MLT_MODE_FLD +: 2]);
                        end
                    end
                    `MLT_REG_KVLAN:  next_st.kvlan = wm[11:0];
                    `MLT_REG_KADDRL: next_st.kaddr[31:0] = wm;
                    `MLT_REG_KADDRH: next_st.kaddr[47:32] = wm[15:0];
                    `MLT_REG_KPORTS: next_st.kports = wm;
                    `MLT_REG_CMD: begin
                        if (!st.busy && wv[2:0] >= `MLT_CMD_NEXT &&
                            wv[2:0] <= `MLT_CMD_CLRB) begin
                            next_st.cmd_pend = 1'b1;
                            next_st.busy = 1'b1;
                            next_st.found = 1'b0;
                            next_st.err = 1'b0;
                            next_st.cmd_op = mlt_op_t'(wv[2:0]);
                            next_st.cmd_bit = wv[`MLT_CMD_PORT +: 5];
                        end
                    end
                    default: begin
                        // Unmapped: answered, nothing stored
                    end
                endcase
            end
        end
        // Each tick sets the sweep request; set wins over the clear
        if (tick) begin
            next_st.age_pend = 1'b1;
        end
        next_st.in_ready = (next_st.state == S_IDLE) && !next_st.age_pend &&
                           !next_st.cmd_pend;
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            st <= '0;
            st.state <= S_INIT;
            st.waitreq <= 1'b1;
            st.age_time <= `MLT_AGE_DEF;
        end else begin
            st <= next_st;
        end
    end

    assign avs_readdata = st.rdata;
    assign avs_waitrequest = st.waitreq;
    assign in_ready = st.in_ready;
    assign out_valid = st.out_valid;
    assign out_ports = st.out_ports[PORTS-1:0];
    assign out_drop = st.out_drop;
endmodule
`default_nettype wire

// ### include/mlt_consts.svh
`ifndef MLT_CONSTS_SVH
`define MLT_CONSTS_SVH
`define MLT_CLK_HZ      50000000
`define MLT_PORTS_DEF   28
`define MLT_DEPTH_DEF   8192
`define MLT_STATIC_MAX  64
`define MLT_AGE_DEF     24'h00012c
`define MLT_AGE_MIN     32'h0000000a
`define MLT_AGE_MAX     32'h00989680
`define MLT_REG_CTRL    6'h00
`define MLT_REG_AGE     6'h04
`define MLT_REG_MODE    6'h08
`define MLT_REG_KVLAN   6'h0c
`define MLT_REG_KADDRL  6'h10
`define MLT_REG_KADDRH  6'h14
`define MLT_REG_KPORTS  6'h18
`define MLT_REG_CMD     6'h1c
`define MLT_REG_RVLAN   6'h20
`define MLT_REG_RADDRL  6'h24
`define MLT_REG_RADDRH  6'h28
`define MLT_REG_RPORTS  6'h2c
`define MLT_CMD_NEXT    3'h1
`define MLT_CMD_ADD     3'h2
`define MLT_CMD_DEL     3'h3
`define MLT_CMD_SETB    3'h4
`define MLT_CMD_CLRB    3'h5
`define MLT_MODE_FLD    8
`define MLT_MODE_LOCK   12
`define MLT_MODE_APPLY  16
`define MLT_CMD_PORT    8
`endif

// ### include/mlt_pkg.sv
`default_nettype none
package mlt_pkg;
    typedef logic [11:0] mlt_vlan_t;
    typedef logic [47:0] mlt_hwaddr_t;
    typedef logic [59:0] mlt_key_t;
    typedef logic [4:0]  mlt_pidx_t;
    typedef logic [31:0] mlt_pmask_t;
    typedef logic [23:0] mlt_sec_t;
    typedef enum logic [1:0] {
        MLT_AUTO    = 2'b00,
        MLT_DISABLE = 2'b01,
        MLT_SECURE  = 2'b10
    } mlt_learn_t;
    typedef enum logic [2:0] {
        OP_FRAME = 3'b000,
        OP_NEXT  = 3'b001,
        OP_ADD   = 3'b010,
        OP_DEL   = 3'b011,
        OP_SETB  = 3'b100,
        OP_CLRB  = 3'b101,
        OP_AGE   = 3'b110
    } mlt_op_t;
    typedef enum logic [1:0] {
        S_INIT = 2'b00,
        S_IDLE = 2'b01,
        S_SCAN = 2'b10,
        S_DONE = 2'b11
    } mlt_state_t;
    typedef struct packed {
        logic        valid;
        logic        stat;
        mlt_vlan_t   vlan;
        mlt_hwaddr_t addr;
        mlt_pmask_t  ports;
        mlt_sec_t    stamp;
    } mlt_entry_t;
endpackage
`default_nettype wire

// ### include/mlt_mem_if.sv
`timescale 1ns/100ps
`default_nettype none
interface mlt_mem_if #(
    parameter int AW = 13,
    parameter int W  = 118
);
    logic [AW-1:0] raddr;
    logic [AW-1:0] waddr;
    logic [W-1:0]  rdata;
    logic [W-1:0]  wdata;
    logic          we;
    modport ctl (output raddr, waddr, wdata, we, input rdata);
    modport mem (input raddr, waddr, wdata, we, output rdata);
endinterface
`default_nettype wire

// ### src/mlt_mem.sv
`timescale 1ns/100ps
`default_nettype none
module mlt_mem #(
    parameter int DEPTH = 8192,
    parameter int AW    = 13,
    parameter int W     = 118
) (
    input wire logic clock,
    mlt_mem_if.mem   m
);
    logic [W-1:0] ram [DEPTH];

    if (DEPTH > (1 << AW)) begin : g_chk
        $error("DEPTH does not fit AW");
    end

    always_ff @(posedge clock) begin
        if (m.we) begin
            ram[m.waddr] <= m.wdata;
        end
        m.rdata <= ram[m.raddr];
    end
endmodule
`default_nettype wire

// ### src/mlt_sec_timer.sv
`timescale 1ns/100ps
`default_nettype none
`include "mlt_consts.svh"
module mlt_sec_timer #(
    parameter int CLK_HZ = `MLT_CLK_HZ
) (
    input  wire logic           clock,
    input  wire logic           rst,
    output logic                tick,
    output var mlt_pkg::mlt_sec_t now
);
    import mlt_pkg::*;
    localparam int CW = $clog2(CLK_HZ);
    typedef struct packed {
        logic [CW-1:0] cnt;
        mlt_sec_t      now;
        logic          tick;
    } mlt_tmr_state_t;
    mlt_tmr_state_t st;
    mlt_tmr_state_t next_st;

    if (CLK_HZ < 2) begin : g_chk
        $error("CLK_HZ must be at least 2");
    end

    // One-cycle enable once per second, plus a free-running seconds count
    always_comb begin
        next_st = st;
        next_st.tick = 1'b0;
        if (st.cnt == CW'(CLK_HZ - 1)) begin
            next_st.cnt = '0;
            next_st.tick = 1'b1;
            next_st.now = st.now + 1'b1;
        end else begin
            next_st.cnt = st.cnt + 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign tick = st.tick;
    assign now = st.now;
endmodule
`default_nettype wire

// ### tb/mlt_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module mlt_asserts #(
    parameter int PORTS = 28,
    parameter int DEPTH = 8192
) (
    input wire logic             clock,
    input wire logic             rst,
    input wire logic             avs_read,
    input wire logic             avs_write,
    input wire logic             avs_waitrequest,
    input wire logic             in_valid,
    input wire logic             in_ready,
    input wire logic             out_valid,
    input wire logic [PORTS-1:0] out_ports,
    input wire logic             out_drop
);
    int cnt;
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    sequence s_req;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence s_take;
        in_valid && in_ready;
    endsequence
    // Cycles since the last accepted frame
    always_ff @(posedge clock) begin
        if (rst)
            cnt <= 0;
        else if (in_valid && in_ready)
            cnt <= 1;
        else if (out_valid)
            cnt <= 0;
        else if (cnt != 0)
            cnt <= cnt + 1;
    end
    a_bus_answer: assert property (s_req |=> !avs_waitrequest)
        else $error("no answer");
    a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("long answer");
    a_take_busy: assert property (s_take |=> !in_ready [*2])
        else $error("ready while busy");
    a_frame_time: assert property (cnt == DEPTH + 3 |-> out_valid)
        else $error("decision late");
    a_no_stray: assert property (out_valid |-> cnt == DEPTH + 3)
        else $error("stray decision");
    a_out_pulse: assert property (out_valid |=> !out_valid)
        else $error("long pulse");
    a_drop_zero: assert property (out_valid && out_drop
        |-> out_ports == '0) else $error("dropped with ports");
    a_result_hold: assert property (!out_valid |-> $stable(out_ports)
        && $stable(out_drop)) else $error("decision moved");
endmodule
bind mlt_table mlt_asserts #(.PORTS(PORTS), .DEPTH(DEPTH)) i_chk (
    .clock(clock), .rst(rst), .avs_read(avs_read), .avs_write(avs_write),
    .avs_waitrequest(avs_waitrequest), .in_valid(in_valid),
    .in_ready(in_ready), .out_valid(out_valid), .out_ports(out_ports),
    .out_drop(out_drop));
`default_nettype wire

// ### tb/mlt_port_model.sv
`timescale 1ns/100ps
`default_nettype none
module mlt_port_model (
    input  wire logic                clock,
    input  wire logic                in_ready,
    output var logic                 in_valid,
    output var mlt_pkg::mlt_pidx_t   in_port,
    output var mlt_pkg::mlt_vlan_t   in_vlan,
    output var mlt_pkg::mlt_hwaddr_t in_dest,
    output var mlt_pkg::mlt_hwaddr_t in_src
);
    import mlt_pkg::*;
    initial begin
        in_valid = 1'b0;
        {in_port, in_vlan, in_dest, in_src} = '0;
    end
    // Held until taken, then inverted so stale fields never look valid
    task automatic send(mlt_pidx_t p, mlt_vlan_t v, mlt_hwaddr_t d,
                        mlt_hwaddr_t s);
        in_valid <= 1'b1;
        {in_port, in_vlan, in_dest, in_src} <= {p, v, d, s};
        do @(posedge clock); while (!in_ready);
        in_valid <= 1'b0;
        {in_port, in_vlan, in_dest, in_src} <= ~{p, v, d, s};
    endtask
endmodule
`default_nettype wire

// ### tb/mlt_table_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "mlt_consts.svh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin bad_count++; \
    $display("wrong value t=%0t got=%h exp=%h", $time, a, b); end end
module mlt_table_tb;
    import mlt_pkg::*;
    localparam int       P  = 28;
    localparam mlt_key_t KA = 60'h0050000000000a1;
    localparam mlt_key_t KB = 60'h0020000000000b2;
    localparam mlt_key_t KC = 60'h0010000000000c3;
    int           bad_count = 0;
    int           n_checks  = 0;
    logic         clock     = 1'b0;
    logic         rst       = 1'b1;
    logic         avs_read  = 1'b0;
    logic         avs_write = 1'b0;
    logic [5:0]   avs_address   = '0;
    logic [31:0]  avs_writedata = '0;
    logic [31:0]  avs_readdata;
    logic         avs_waitrequest, in_valid, in_ready, out_valid, out_drop;
    logic [P-1:0] mode_lock = '0;
    logic [P-1:0] out_ports;
    mlt_pidx_t    in_port;
    mlt_vlan_t    in_vlan;
    mlt_hwaddr_t  in_dest, in_src;
    mlt_table #(.PORTS(P), .DEPTH(64), .CLK_HZ(100)) i_dut (
        .clock, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest, .mode_lock,
        .in_valid, .in_ready, .in_port, .in_vlan, .in_dest, .in_src,
        .out_valid, .out_ports, .out_drop);
    mlt_port_model i_pm (.clock, .in_ready, .in_valid, .in_port, .in_vlan,
        .in_dest, .in_src);
    task automatic bus(logic w, logic [5:0] a, logic [31:0] d,
                       output logic [31:0] q);
        {avs_address, avs_writedata, avs_write, avs_read} <= {a, d, w, !w};
        do @(posedge clock); while (avs_waitrequest);
        q = avs_readdata;
        {avs_write, avs_read} <= 2'b00;
        @(posedge clock);
    endtask
    task automatic rd(logic [5:0] a, output logic [31:0] q);
        bus(1'b0, a, '0, q);
    endtask
    task automatic wr(logic [5:0] a, logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic cmd(mlt_key_t k, logic [31:0] pm, logic [31:0] c,
                       output logic [31:0] q);
        wr(6'h0c, {20'h0, k[59:48]});
        wr(6'h10, k[31:0]);
        wr(6'h14, {16'h0, k[47:32]});
        wr(6'h18, pm);
        wr(6'h1c, c);
        do rd(6'h1c, q); while (q[0]);
    endtask
    task automatic gn(mlt_key_t k, logic f, logic s, mlt_key_t ek,
                      logic [P-1:0] ep);
        logic [31:0] q, v, l, h, p;
        cmd(k, '0, 32'h1, q);
        rd(6'h20, v);
        rd(6'h24, l);
        rd(6'h28, h);
        rd(6'h2c, p);
        `CHK(q[1], f)
        if (f) begin
            `CHK(q[2], s)
            `CHK({v[11:0], h[15:0], l}, ek)
            `CHK(p[P-1:0], ep)
        end
    endtask
    task automatic fr(mlt_pidx_t p, mlt_vlan_t v, mlt_hwaddr_t s,
                      mlt_hwaddr_t d, logic dr, logic [P-1:0] ep);
        i_pm.send(p, v, d, s);
        do @(posedge clock); while (!out_valid);
        `CHK(out_drop, dr)
        `CHK(out_ports, ep)
    endtask
    task automatic t_regs;
        logic [31:0] q;
        rd(6'h04, q);
        `CHK(q[23:0], `MLT_AGE_DEF)
        rd(6'h00, q);
        `CHK(q[0], 1'b0)
        rd(6'h30, q);
        `CHK(q, 32'h0)
        wr(6'h04, 32'h9);
        wr(6'h04, 32'h989681);
        rd(6'h04, q);
        `CHK(q[23:0], `MLT_AGE_DEF)
        wr(6'h04, 32'h989680);
        rd(6'h04, q);
        `CHK(q[23:0], 24'h989680)
    endtask
    task automatic t_learn;
        fr(5'd3, 12'h5, KA[47:0], 48'hff, 1'b0, ~(28'h1 << 3));
        fr(5'd3, 12'h5, KA[47:0], KA[47:0], 1'b0, 28'h8);
        gn(KA, 1'b1, 1'b0, KA, 28'h8);
    endtask
    task automatic t_static;
        logic [31:0] q;
        cmd(KB, 32'h6, 32'h2, q);
        cmd(KC, 32'h1, 32'h2, q);
        gn('0, 1'b1, 1'b1, KC, 28'h1);
        gn(60'h002000000000000, 1'b1, 1'b1, KB, 28'h6);
        cmd(KB, '0, 32'h704, q);
        cmd(KB, '0, 32'h105, q);
        fr(5'd8, 12'h2, KB[47:0], KB[47:0], 1'b0, 28'h84);
        gn(KB, 1'b1, 1'b1, KB, 28'h84);
        gn(KB + 1, 1'b1, 1'b0, KA, 28'h8);
    endtask
    task automatic t_modes;
        logic [31:0] q;
        wr(6'h08, 32'h10204);
        fr(5'd4, 12'h2, 48'h77, KB[47:0], 1'b1, '0);
        fr(5'd4, 12'h2, KB[47:0], 48'hff, 1'b0, ~(28'h1 << 4));
        wr(6'h08, 32'h10106);
        fr(5'd6, 12'h9, 48'hd4, 48'hff, 1'b0, ~(28'h1 << 6));
        gn(60'h009000000000000, 1'b0, 1'b0, '0, '0);
        mode_lock[9] <= 1'b1;
        wr(6'h08, 32'h10209);
        rd(6'h08, q);
        `CHK({q[12], q[9:8]}, 3'b100)
    endtask
    task automatic t_age;
        logic [31:0] q;
        wr(6'h00, 32'h1);
        wr(6'h04, 32'ha);
        rd(6'h04, q);
        `CHK(q[23:0], 24'ha)
        repeat (1500) @(posedge clock);
        gn(KA, 1'b1, 1'b0, KA, 28'h8);
        wr(6'h00, 32'h0);
        repeat (300) @(posedge clock);
        gn(KA, 1'b0, 1'b0, '0, '0);
        gn(KC, 1'b1, 1'b1, KC, 28'h1);
        cmd(KC, '0, 32'h3, q);
        `CHK(q[3], 1'b0)
        gn(KC, 1'b1, 1'b1, KB, 28'h84);
        cmd(KC, '0, 32'h3, q);
        `CHK(q[3], 1'b1)
    endtask
    task automatic print_verdict;
        $display("checks %0d errors %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        forever #10 clock = ~clock;
    end
    initial begin
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        do @(posedge clock); while (!in_ready);
        t_regs();
        t_learn();
        t_static();
        t_modes();
        t_age();
        print_verdict();
    end
    initial begin
        repeat (40000) @(posedge clock);
        bad_count++;
        print_verdict();
    end
endmodule
`default_nettype wire
